// [dv/tsh_i2c_host_asserts.sv]
// Checker for the two-wire host controller's bus pins and handshakes
module tsh_i2c_host_asserts (
  input wire logic clk,       // System clock
  input wire logic rst_b,     // Reset, active low
  input wire logic cmd_ready, // Command accept pulse
  input wire logic wr_ready,  // Write byte taken
  input wire logic err_nack,  // Target refused a byte
  input wire logic bus_busy,  // Bus seen busy
  input wire logic scl_i,     // Clock line level
  input wire logic scl_oe,    // Clock pulled low
  input wire logic sda_i,     // Data line level
  input wire logic sda_oe     // Data pulled low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Frame tracking
  logic [7:0] cnt_q; // Clock pulls since our start
  logic [7:0] sh_q;  // Data level at each clock pull

  // Bits are captured as the clock is pulled, after the high phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      sh_q  <= 8'h00;
    end else if ($rose(sda_oe) && !scl_oe) begin
      cnt_q <= 8'h00;
    end else if ($rose(scl_oe)) begin
      cnt_q <= cnt_q + 8'h01;
      sh_q  <= {sh_q[6:0], sda_i};
    end
  end

  // Data pulled or freed while the clock line is free
  sequence s_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe;
  endsequence

  // ==========================================================
  // Properties
  a_start_then_busy: assert property (s_start |-> ##[1:12] bus_busy)
    else $error("start not seen as busy");
  a_start_when_free: assert property (s_start |-> !$past(bus_busy))
    else $error("start on a busy bus");
  a_stop_frees_bus: assert property (s_stop |-> ##[1:12] !bus_busy)
    else $error("stop did not free the bus");
  a_stop_on_boundary: assert property (
    s_stop |-> cnt_q % 8'h09 == 8'h01)
    else $error("stop not on a byte boundary");
  a_first_byte_addr: assert property (
    cnt_q == 8'h09 |-> sh_q[7:1] == 7'h78)
    else $error("wrong target address");
  a_addr_ack_free: assert property (
    cnt_q == 8'h09 && !scl_oe |-> !sda_oe)
    else $error("host drove the address ack slot");
  a_nack_ends_frame: assert property (
    $rose(err_nack) |-> ##[0:100] !bus_busy)
    else $error("refused byte not followed by stop");
  a_ready_bus_free: assert property (cmd_ready |-> !bus_busy)
    else $error("command accepted while busy");
  a_wr_under_stall: assert property (wr_ready |-> scl_oe)
    else $error("write byte taken with clock free");
  a_stretch_holds: assert property (
    !$past(scl_oe) && !$past(scl_i) && !scl_oe |-> $stable(sda_oe))
    else $error("data moved during a stall");
endmodule : tsh_i2c_host_asserts

bind tsh_i2c_host tsh_i2c_host_asserts tsh_i2c_host_asserts_inst (
  .clk(clk), .rst_b(rst_b), .cmd_ready(cmd_ready), .wr_ready(wr_ready),
  .err_nack(err_nack), .bus_busy(bus_busy), .scl_i(scl_i),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_oe(sda_oe));

// [dv/tsh_i2c_host_bench.sv]
// Testbench: two-wire host against the target model
module tsh_i2c_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_b = 0, nak = 0, wtk = 0, hold_rd = 0, rival = 0;
  logic       cmd_valid = 0, cmd_read = 0, wr_valid = 0, rd_ready = 0;
  logic [7:0] cmd_reg = 0, cmd_len = 0, wr_data = 0;
  logic [3:0] stretch = 0;                // Target stall per byte
  logic       cmd_ready, wr_ready, rd_valid, done, err_nack, err_arb;
  logic       bus_busy, scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_o, sda_o;
  logic [7:0] rd_data;
  logic [7:0] exp_mem [256];             // Expected register file
  logic [7:0] wq[$], got[$];             // Bytes to send, bytes read
  int         fail_count = 0, tests_run = 0;
  wire        scl = !(scl_oe || m_scl_oe); // Wired-AND with pull-up
  wire        sda = !(sda_oe || m_sda_oe || rival); // Rival master too

  always #20 clk = !clk;

  tsh_i2c_host #(.QTR_CYC(4)) tsh_i2c_host_inst (
    .clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_read, .cmd_reg, .cmd_len,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .done,
    .err_nack, .err_arb, .bus_busy, .scl_i(scl), .scl_o, .scl_oe,
    .sda_i(sda), .sda_o, .sda_oe);
  tsh_target_model tsh_target_model_inst (
    .clk, .rst_b, .scl, .sda, .nak, .stretch, .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // Write bytes held until taken; read side stalls at random
  always @(negedge clk) begin
    if (wtk) void'(wq.pop_front());
    wtk = wr_valid && wr_ready;
    if (!wtk) wr_valid = wq.size() != 0;
    if (!wtk) wr_data = (wq.size() != 0) ? wq[0] : 8'h00;
    // Ready is set first: the byte leaves at the next rising edge
    rd_ready = !hold_rd && $urandom_range(2) != 0;
    if (rd_valid === 1'b1 && rd_ready) got.push_back(rd_data);
  end

  // One command end to end, then its results compared
  task automatic run(input logic rd, input logic [7:0] r, n,
                     input logic nk);
    int         i;
    logic [7:0] b;
    {cmd_read, cmd_reg, cmd_len, nak, cmd_valid} = {rd, r, n, nk, 1'b1};
    got.delete();
    for (i = 0; i < n && !rd; i++) begin
      b = 8'($urandom);
      wq.push_back(b);
      if (!nk) exp_mem[8'(r + i)] = b;
    end
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 0;
    for (i = 0; done !== 1'b1 && i < 20000; i++) @(negedge clk);
    chk(16'(done), 16'h0001);
    for (i = 0; rd_valid === 1'b1 && i < 50; i++) @(negedge clk);
    chk(16'(err_nack), 16'(nk));
    chk(16'(err_arb), 16'h0000);
    chk(16'({scl_o, sda_o}), 16'h0000);
    chk(16'(got.size()), (rd && !nk) ? 16'(n) : 16'h0000);
    foreach (got[j]) chk(16'(got[j]), 16'(exp_mem[8'(r + j)]));
    wq.delete();
  endtask : run

  initial begin
    int         k;
    logic [7:0] r;
    foreach (exp_mem[i]) exp_mem[i] = 8'h00;
    void'($urandom(32'h2de452af));
    repeat (16) @(negedge clk);
    rst_b = 1;
    @(negedge clk);
    run(1'b0, 8'hfe, 8'h03, 1'b0); // Index wraps
    run(1'b1, 8'hfe, 8'h03, 1'b0);
    run(1'b1, 8'h10, 8'h00, 1'b0); // Index write only
    for (k = 0; k < 6; k++) begin
      r = 8'($urandom);
      stretch = 4'($urandom);
      run(1'b0, r, 8'($urandom_range(4, 1)), 1'b0);
      run(1'b1, r, 8'h04, 1'b0);
    end
    // Reader stalls long enough to fill the buffer
    hold_rd = 1;
    fork
      run(1'b1, r, 8'h04, 1'b0);
      begin
        repeat (3000) @(negedge clk);
        hold_rd = 0;
      end
    join
    // A rival master holds data low through our first address bit
    {cmd_read, cmd_len, cmd_valid} = {1'b0, 8'h00, 1'b1};
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 0;
    while (scl_oe !== 1'b1) @(negedge clk);
    rival = 1;
    for (k = 0; done !== 1'b1 && k < 2000; k++) @(negedge clk);
    chk(16'({done, err_arb, err_nack}), 16'h0006);
    rival = 0;
    run(1'b0, 8'h20, 8'h02, 1'b1);
    run(1'b1, 8'h20, 8'h02, 1'b0);
    end_sim;
  end

  // Hang guard, well past the longest expected run
  initial begin
    #4000000;
    fail_count++;
    end_sim;
  end
endmodule : tsh_i2c_host_bench

// [dv/tsh_target_model.sv]
// Touch sensor target model: register file behind the two-wire bus
module tsh_target_model (
  input wire logic       clk,     // Sampling clock
  input wire logic       rst_b,   // Reset, active low
  input wire logic       scl,     // Clock line level
  input wire logic       sda,     // Data line level
  input wire logic       nak,     // Refuse the address
  input wire logic [3:0] stretch, // Stall cycles after each ack
  output logic           scl_oe,  // Hold clock low
  output logic           sda_oe   // Pull data low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];        // Register file
  logic [7:0] sh, tx, ptr;      // Shifter, send byte, index
  logic [3:0] bn, cnt;          // Bit slot (f before first), stall
  logic       scl_p, sda_p, act, rw, seg0, seg1, mack;

  assign scl_oe = cnt != 4'h0;
  initial foreach (mem[i]) mem[i] = 8'h00;

  // Edges found by sampling; all changes land while clock is low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_p, sda_p, act, sda_oe, cnt, bn} <= {4'b1100, 4'h0, 4'hf};
    end else begin
      {scl_p, sda_p} <= {scl, sda};
      if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (scl && scl_p && sda != sda_p) begin
        {seg0, seg1, sda_oe, act, bn} <= {4'b1100, 4'hf};
      end else if (scl && !scl_p) begin
        if (bn < 4'h8) sh <= {sh[6:0], sda};
        else if (bn == 4'h8) mack <= !sda;
      end else if (!scl && scl_p) begin
        bn <= (bn == 4'h8) ? 4'h0 : bn + 4'h1;
        if (bn == 4'h7) begin
          if (seg0) begin
            act    <= sh[7:1] == 7'h78 && !nak;
            sda_oe <= sh[7:1] == 7'h78 && !nak;
            rw     <= sh[0];
          end else if (act && !rw) begin
            if (seg1) ptr <= sh;
            else mem[ptr] <= sh;
            if (!seg1) ptr <= ptr + 8'h01;
            {seg1, sda_oe} <= 2'b01;
          end else sda_oe <= 1'b0;
        end else if (bn == 4'h8) begin
          seg0 <= 1'b0;
          if (act) cnt <= stretch;
          if (act && rw && (seg0 || mack)) begin
            tx     <= mem[ptr];
            ptr    <= ptr + 8'h01;
            sda_oe <= !mem[ptr][7];
          end else sda_oe <= 1'b0;
        end else if (act && rw && !seg0) sda_oe <= !tx[4'h6 - bn];
      end
    end
  end
endmodule : tsh_target_model

// [pkg/tsh_defines.svh]
// Constants for the touch sensor two-wire host controller
`ifndef TSH_DEFINES_SVH
`define TSH_DEFINES_SVH

// ==========================================================================
// Bus addressing
// ==========================================================================
`define TSH_DEV_ADDR    7'h78  // Seven-bit target address, first byte 0xf0
`define TSH_DIR_WR      1'b0   // Direction bit for a write
`define TSH_DIR_RD      1'b1   // Direction bit for a read
`define TSH_BYTE_BITS   4'h8   // Data bits in one byte, ack slot follows

// ==========================================================================
// Timing
// ==========================================================================
`define TSH_CLK_PERIOD_NS 40     // System clock period
`define TSH_SCL_PERIOD_NS 10000  // Serial clock period we generate
// Quarter serial period in system clocks, rounded up
`define TSH_QTR_CYC ((`TSH_SCL_PERIOD_NS + 4 * `TSH_CLK_PERIOD_NS - 1) \
                     / (4 * `TSH_CLK_PERIOD_NS))

`endif

// [pkg/tsh_pkg.sv]
// Types shared by the touch sensor two-wire host controller
package tsh_pkg;

  // ========================================================================
  // Main sequencer states
  // ========================================================================
  typedef enum logic [2:0] {
    TSH_ST_IDLE  = 3'b000,  // Waiting for a command
    TSH_ST_START = 3'b001,  // Forming a start condition
    TSH_ST_BIT   = 3'b010,  // Clocking one data or ack bit
    TSH_ST_HOLD  = 3'b011,  // Clock held low, waiting on user data/space
    TSH_ST_STOP  = 3'b100   // Forming a stop condition
  } tsh_state_t;

  // ========================================================================
  // Which byte of the transfer is on the wire
  // ========================================================================
  typedef enum logic [1:0] {
    TSH_SEG_ADDR  = 2'b00,  // Address and direction byte
    TSH_SEG_REG   = 2'b01,  // Register index byte
    TSH_SEG_WDATA = 2'b10,  // Write data byte
    TSH_SEG_RDATA = 2'b11   // Read data byte
  } tsh_seg_t;

endpackage : tsh_pkg

// [rtl/tsh_i2c_host.sv]
// Two-wire bus host that reads and writes the touch sensor's registers
// Function
// - Data changes only while clock is low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Eight bits MSB first, then ack slot
// - Wait while target stretches clock low
// - Receiver pulls data low in ack slot
// - Target nack ends transfer with stop
// - Host nacks last read byte, then stops
// - Clock low follows longest, high shortest (high is a fixed count here, not cut short)
// - Start transfer only when bus free
// - Lose arbitration: stop driving data
// - Write address byte is 0xf0
// - Write: address, register index, data bytes
// - Read: set index, stop, then 0xf1
`include "tsh_defines.svh"

module tsh_i2c_host #(
  parameter int DW      = 8,             // Data byte width
  parameter int QTR_CYC = `TSH_QTR_CYC   // Quarter serial period in clocks
) (
  input  wire logic          clk,        // System clock, 25 MHz
  input  wire logic          rst_b,      // Asynchronous reset, active low
  input  wire logic          cmd_valid,  // Command request
  output logic               cmd_ready,  // Command taken when both high
  input  wire logic          cmd_read,   // One: read, zero: write
  input  wire logic [7:0]    cmd_reg,    // First register index
  input  wire logic [7:0]    cmd_len,    // Number of data bytes
  input  wire logic          wr_valid,   // Write byte offered
  output logic               wr_ready,   // Write byte taken when both high
  input  wire logic [DW-1:0] wr_data,    // Write byte
  output logic               rd_valid,   // Read byte available
  input  wire logic          rd_ready,   // User takes read byte
  output logic [DW-1:0]      rd_data,    // Read byte
  output logic               done,       // One-cycle pulse at end
  output logic               err_nack,   // Target refused a byte
  output logic               err_arb,    // Arbitration lost
  output logic               bus_busy,   // Bus seen busy
  input  wire logic          scl_i,      // Clock line level
  output logic               scl_o,      // Clock drive value, always low
  output logic               scl_oe,     // Clock pulled low when high
  input  wire logic          sda_i,      // Data line level
  output logic               sda_o,      // Data drive value, always low
  output logic               sda_oe      // Data pulled low when high
);

  // ========================================================================
  // Declarations
  // ========================================================================
  logic [7:0]         qtr;                // Quarter period as a byte
  logic [7:0]         half;               // Half period as a byte
  logic               scl_m_q, scl_s_q;   // Clock synchroniser
  logic               sda_m_q, sda_s_q;   // Data synchroniser
  logic               sda_p_q;            // Data one cycle older
  tsh_pkg::tsh_state_t st_q, st_d;        // Sequencer state
  tsh_pkg::tsh_seg_t  seg_q, seg_d;       // Current byte kind
  logic [1:0]         stp_q, stp_d;       // Step within a state
  logic [7:0]         tmr_q, tmr_d;       // Phase timer
  logic [3:0]         bit_q, bit_d;       // Bit index, 8 is ack slot
  logic [7:0]         shf_q, shf_d;       // Shift register
  logic [7:0]         reg_q, reg_d;       // Register index held
  logic [7:0]         cnt_q, cnt_d;       // Data bytes left
  logic               rdm_q, rdm_d;       // Command is a read
  logic               two_q, two_d;       // In second part of a read
  logic               nack_q, nack_d;     // Sampled ack slot level
  logic               busy_q, busy_d;     // Bus busy tracker
  logic               scl_oe_q, scl_oe_d; // Clock pull-down
  logic               sda_oe_q, sda_oe_d; // Data pull-down
  logic               crdy_q, crdy_d;     // Command ready
  logic               wrdy_q, wrdy_d;     // Write ready
  logic               done_q, done_d;     // Done pulse
  logic               enak_q, enak_d;     // Nack error level
  logic               earb_q, earb_d;     // Arbitration error level
  logic               push;               // Received byte into buffer
  logic               rx;                 // Current byte is read data
  logic [DW-1:0]      e0_q, e0_d;         // Buffer head entry
  logic [DW-1:0]      e1_q, e1_d;         // Buffer spare entry
  logic               v0_q, v0_d;         // Head valid
  logic               v1_q, v1_d;         // Spare valid

  assign qtr  = QTR_CYC[7:0];
  assign half = {qtr[6:0], 1'b0};

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  // Two flops per line; only the second, and its one-cycle-older data copy, feeds any logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // ========================================================================
  // Sequencer
  // ========================================================================
  // Read data bytes are the only ones the target drives
  assign rx = (seg_q == tsh_pkg::TSH_SEG_RDATA);

  // Next-state logic for the transfer sequencer
  always_comb begin
    st_d     = st_q;
    seg_d    = seg_q;
    stp_d    = stp_q;
    tmr_d    = tmr_q + 8'h01;
    bit_d    = bit_q;
    shf_d    = shf_q;
    reg_d    = reg_q;
    cnt_d    = cnt_q;
    rdm_d    = rdm_q;
    two_d    = two_q;
    nack_d   = nack_q;
    busy_d   = busy_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    wrdy_d   = 1'b0;
    done_d   = 1'b0;
    enak_d   = enak_q;
    earb_d   = earb_q;
    push     = 1'b0;
    // Watch every master's start and stop, ours included
    if (scl_s_q && sda_p_q && !sda_s_q) begin
      busy_d = 1'b1;
    end else if (scl_s_q && !sda_p_q && sda_s_q) begin
      busy_d = 1'b0;
    end
    unique case (st_q)
      tsh_pkg::TSH_ST_IDLE: begin
        // Lines released, timer parked
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        tmr_d    = 8'h00;
        if (cmd_valid && crdy_q) begin
          st_d   = tsh_pkg::TSH_ST_START;
          stp_d  = 2'b00;
          seg_d  = tsh_pkg::TSH_SEG_ADDR;
          two_d  = 1'b0;
          rdm_d  = cmd_read;
          reg_d  = cmd_reg;
          cnt_d  = cmd_len;
          shf_d  = {`TSH_DEV_ADDR, `TSH_DIR_WR};
          enak_d = 1'b0;
          earb_d = 1'b0;
        end
      end
      tsh_pkg::TSH_ST_START: begin
        unique case (stp_q)
          2'b00: begin
            // Free data first, so a restart from clock low is clean
            sda_oe_d = 1'b0;
            if (tmr_q == qtr) begin
              stp_d = 2'b01;
              tmr_d = 8'h00;
            end
          end
          2'b01: begin
            scl_oe_d = 1'b0;
            tmr_d    = 8'h00;
            if (scl_s_q && sda_s_q) begin
              stp_d = 2'b10;
            end
          end
          2'b10: begin
            if (tmr_q == half) begin
              sda_oe_d = 1'b1;
              stp_d    = 2'b11;
              tmr_d    = 8'h00;
            end
          end
          2'b11: begin
            if (tmr_q == half) begin
              scl_oe_d = 1'b1;
              st_d     = tsh_pkg::TSH_ST_BIT;
              stp_d    = 2'b00;
              bit_d    = 4'h0;
              tmr_d    = 8'h00;
            end
          end
        endcase
      end
      tsh_pkg::TSH_ST_BIT: begin
        unique case (stp_q)
          2'b00: begin
            // Data set while clock is low
            if (bit_q != `TSH_BYTE_BITS) begin
              sda_oe_d = !rx && !shf_q[7];
            end else begin
              // Ack every read byte but the last one
              sda_oe_d = rx && (cnt_q != 8'h01);
            end
            if (tmr_q == half) begin
              scl_oe_d = 1'b0;
              stp_d    = 2'b01;
              tmr_d    = 8'h00;
            end
          end
          2'b01: begin
            // High time counts from when the line is really high
            tmr_d = 8'h00;
            if (scl_s_q) begin
              stp_d = 2'b10;
            end
          end
          2'b10: begin
            if (tmr_q == qtr) begin
              stp_d = 2'b11;
              tmr_d = 8'h00;
              if (bit_q != `TSH_BYTE_BITS) begin
                shf_d = {shf_q[6:0], sda_s_q};
                if (!rx && !sda_oe_q && !sda_s_q) begin
                  // Another master drove low: back off at once
                  st_d     = tsh_pkg::TSH_ST_IDLE;
                  scl_oe_d = 1'b0;
                  sda_oe_d = 1'b0;
                  earb_d   = 1'b1;
                  done_d   = 1'b1;
                end
              end else begin
                nack_d = sda_s_q;
              end
            end
          end
          2'b11: begin
            if (tmr_q == qtr) begin
              scl_oe_d = 1'b1;
              stp_d    = 2'b00;
              tmr_d    = 8'h00;
              if (bit_q != `TSH_BYTE_BITS) begin
                bit_d = bit_q + 4'h1;
              end else begin
                bit_d = 4'h0;
                if (!rx && nack_q) begin
                  enak_d = 1'b1;
                  st_d   = tsh_pkg::TSH_ST_STOP;
                end else begin
                  unique case (seg_q)
                    tsh_pkg::TSH_SEG_ADDR: begin
                      if (two_q) begin
                        seg_d = tsh_pkg::TSH_SEG_RDATA;
                        st_d  = tsh_pkg::TSH_ST_HOLD;
                      end else begin
                        seg_d = tsh_pkg::TSH_SEG_REG;
                        shf_d = reg_q;
                      end
                    end
                    tsh_pkg::TSH_SEG_REG: begin
                      if (rdm_q || cnt_q == 8'h00) begin
                        st_d = tsh_pkg::TSH_ST_STOP;
                      end else begin
                        seg_d = tsh_pkg::TSH_SEG_WDATA;
                        st_d  = tsh_pkg::TSH_ST_HOLD;
                      end
                    end
                    tsh_pkg::TSH_SEG_WDATA: begin
                      cnt_d = cnt_q - 8'h01;
                      st_d  = (cnt_q == 8'h01) ? tsh_pkg::TSH_ST_STOP
                                               : tsh_pkg::TSH_ST_HOLD;
                    end
                    tsh_pkg::TSH_SEG_RDATA: begin
                      push  = 1'b1;
                      cnt_d = cnt_q - 8'h01;
                      st_d  = (cnt_q == 8'h01) ? tsh_pkg::TSH_ST_STOP
                                               : tsh_pkg::TSH_ST_HOLD;
                    end
                  endcase
                end
              end
            end
          end
        endcase
      end
      tsh_pkg::TSH_ST_HOLD: begin
        // Clock held low stalls the bus until the user side is ready
        tmr_d = 8'h00;
        if (rx) begin
          sda_oe_d = 1'b0;
          if (!v1_q) begin
            st_d = tsh_pkg::TSH_ST_BIT;
          end
        end else begin
          wrdy_d = wr_valid && !wrdy_q;
          if (wr_valid && wrdy_q) begin
            shf_d = wr_data[7:0];
            st_d  = tsh_pkg::TSH_ST_BIT;
          end
        end
      end
      tsh_pkg::TSH_ST_STOP: begin
        unique case (stp_q)
          2'b00: begin
            sda_oe_d = 1'b1;
            if (tmr_q == qtr) begin
              stp_d = 2'b01;
              tmr_d = 8'h00;
            end
          end
          2'b01: begin
            scl_oe_d = 1'b0;
            tmr_d    = 8'h00;
            if (scl_s_q) begin
              stp_d = 2'b10;
            end
          end
          2'b10: begin
            if (tmr_q == half) begin
              sda_oe_d = 1'b0;
              stp_d    = 2'b11;
              tmr_d    = 8'h00;
            end
          end
          2'b11: begin
            // Bus-free time before a new start
            if (tmr_q == half) begin
              stp_d = 2'b00;
              tmr_d = 8'h00;
              if (rdm_q && !two_q && cnt_q != 8'h00 && !enak_q) begin
                two_d = 1'b1;
                seg_d = tsh_pkg::TSH_SEG_ADDR;
                shf_d = {`TSH_DEV_ADDR, `TSH_DIR_RD};
                st_d  = tsh_pkg::TSH_ST_START;
              end else begin
                st_d   = tsh_pkg::TSH_ST_IDLE;
                done_d = 1'b1;
              end
            end
          end
        endcase
      end
      default: begin
        st_d = tsh_pkg::TSH_ST_IDLE;
      end
    endcase
    // Offer a command only while idle and the bus is free
    crdy_d = (st_d == tsh_pkg::TSH_ST_IDLE) && !busy_d && !crdy_q;
  end

  // Registers of the sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= tsh_pkg::TSH_ST_IDLE;
      seg_q    <= tsh_pkg::TSH_SEG_ADDR;
      stp_q    <= 2'b00;
      tmr_q    <= 8'h00;
      bit_q    <= 4'h0;
      shf_q    <= 8'h00;
      reg_q    <= 8'h00;
      cnt_q    <= 8'h00;
      rdm_q    <= 1'b0;
      two_q    <= 1'b0;
      nack_q   <= 1'b0;
      busy_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      crdy_q   <= 1'b0;
      wrdy_q   <= 1'b0;
      done_q   <= 1'b0;
      enak_q   <= 1'b0;
      earb_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      seg_q    <= seg_d;
      stp_q    <= stp_d;
      tmr_q    <= tmr_d;
      bit_q    <= bit_d;
      shf_q    <= shf_d;
      reg_q    <= reg_d;
      cnt_q    <= cnt_d;
      rdm_q    <= rdm_d;
      two_q    <= two_d;
      nack_q   <= nack_d;
      busy_q   <= busy_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      crdy_q   <= crdy_d;
      wrdy_q   <= wrdy_d;
      done_q   <= done_d;
      enak_q   <= enak_d;
      earb_q   <= earb_d;
    end
  end

  // ========================================================================
  // Two-entry read buffer
  // ========================================================================
  // Head entry drives the outputs directly; the spare absorbs one byte
  // while the user stalls, and a full spare stalls the bus clock
  always_comb begin
    e0_d = e0_q;
    e1_d = e1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (v0_q && rd_ready) begin
      e0_d = e1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (push) begin
      if (!v0_d) begin
        e0_d = shf_q[DW-1:0];
        v0_d = 1'b1;
      end else begin
        e1_d = shf_q[DW-1:0];
        v1_d = 1'b1;
      end
    end
  end

  // Registers of the read buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      e0_q <= '0;
      e1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      e0_q <= e0_d;
      e1_q <= e1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end

  // ========================================================================
  // Outputs, all straight from flops
  // ========================================================================
  // Open-drain: the drive value stays low, only the enables move
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign scl_oe    = scl_oe_q;
  assign sda_oe    = sda_oe_q;
  assign cmd_ready = crdy_q;
  assign wr_ready  = wrdy_q;
  assign rd_valid  = v0_q;
  assign rd_data   = e0_q;
  assign done      = done_q;
  assign err_nack  = enak_q;
  assign err_arb   = earb_q;
  assign bus_busy  = busy_q;

endmodule : tsh_i2c_host
